//--- hdl/bstc_pkg.sv
// Summary of operation
// - Bank select sits at the last word of the window, shared by all banks.
// - Three-bit bank code: 0..3 select banks, top bit set selects none.
// - Upper byte of bank select reads 33 hex except during power-down, when the whole word reads zero.
// - Bank select reachable in any bank, but not during power-down.
// - Absent bank: writes dropped, reads return 33 hex per byte.
// - CRC suppress bit set means no CRC appended; clear appends CRC.
// - Switched full duplex: no deferral, no collision detection.
// - Switched full duplex forces full duplex on and carrier monitor off.
// - Policy low with early transmit: underrun when DMA address passes pointer.
// - Policy high with early transmit: underrun when packet numbers match and transmit passes load.
// - Protocol block wrap loops data internally, overrides other loops, no network.
// - Halt bit set stops and disables transmitter on quality test failure, except in switched full duplex.
// - Full duplex or switched full duplex accepts own frames; otherwise own frames are rejected.
// - Carrier monitor: no carrier by preamble end or lost aborts, disables.
// - Padding fills frames under 64 bytes with zero bytes.
// - Forced collision skips deferral and clears itself after the collision.
// - Local loop returns after the codec, ignores collision and carrier, no network.
// - Clearing enable finishes current frame; error stops clear enable.
package bstc_pkg;
	localparam logic [3:0]  OFF_TCR       = 4'h0;
	localparam logic [3:0]  OFF_BSR       = 4'he;
	localparam logic [2:0]  BANK_TX       = 3'h0;
	localparam logic [2:0]  BANK_RST      = 3'h0;
	localparam logic [15:0] TCR_RST       = 16'h0000;
	localparam logic [15:0] TCR_MASK      = 16'hfd8f;
	localparam logic [7:0]  SIGNATURE     = 8'h33;
	localparam logic [10:0] MIN_FRAME_LEN = 11'h040;
	localparam int B_TRANSMITTER_ON  = 0;
	localparam int B_LOOP   = 1;
	localparam int B_FORCED_COLLISION = 2;
	localparam int B_RSVD   = 3;
	localparam int B_PAD    = 7;
	localparam int B_CRC_SUPPRESS  = 8;
	localparam int B_MON    = 10;
	localparam int B_FDX    = 11;
	localparam int B_HALT   = 12;
	localparam int B_WRAP   = 13;
	localparam int B_POLICY = 14;
	localparam int B_SWITCHED_FULL_DUPLEX   = 15;
	typedef enum logic [1:0] {
		LOOP_NONE  = 2'b00,
		LOOP_CODEC = 2'b01,
		LOOP_BLOCK = 2'b10
	} bstc_loop_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE  = 2'b01,
		ST_BODY = 2'b10
	} bstc_tx_e;
endpackage

//--- hdl/bstc_sync3.sv
`timescale 1ns/100ps
module bstc_sync3 (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic d_i,
	output logic      q_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} bstc_sync_s;

	bstc_sync_s s_q;
	bstc_sync_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.s1 = d_i;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		if (s_q.s2 == s_q.s3) begin
			s_d.q = s_q.s3;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.q;
endmodule

//--- hdl/bstc_underrun.sv
`timescale 1ns/100ps
module bstc_underrun #(
	parameter int AW = 11,
	parameter int PW = 6
) (
	input  wire logic          policy_i,
	input  wire logic          early_tx_enable_i,
	input  wire logic [AW-1:0] dma_addr_i,
	input  wire logic [AW-1:0] ptr_addr_i,
	input  wire logic [PW-1:0] load_pkt_i,
	input  wire logic [PW-1:0] tx_pkt_i,
	input  wire logic [AW-1:0] load_addr_i,
	input  wire logic [AW-1:0] tx_addr_i,
	output logic               force_o
);
	always_comb begin
		force_o = 1'b0;
		if (early_tx_enable_i) begin
			if (!policy_i) begin
				force_o = dma_addr_i > ptr_addr_i;
			end else begin
				force_o = (load_pkt_i == tx_pkt_i) && (tx_addr_i > load_addr_i);
			end
		end
	end
endmodule

//--- hdl/bstc_top.sv
`timescale 1ns/100ps
module bstc_top #(
	parameter int AW = 11,
	parameter int PW = 6
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic [3:0]    io_addr_i,
	input  wire logic          io_wr_i,
	input  wire logic          io_rd_i,
	input  wire logic [1:0]    io_be_i,
	input  wire logic [15:0]   io_wdata_i,
	output logic      [15:0]   io_rdata_o,
	output logic               io_rvalid_o,
	input  wire logic          pwrdn_i,
	input  wire logic          carrier_i,
	input  wire logic          tx_start_i,
	input  wire logic          preamble_end_i,
	input  wire logic          frame_end_i,
	input  wire logic          collision_i,
	input  wire logic          signal_quality_test_fail_i,
	input  wire logic          tx_fatal_i,
	input  wire logic [10:0]   frame_len_i,
	input  wire logic          early_tx_enable_i,
	input  wire logic [AW-1:0] dma_addr_i,
	input  wire logic [AW-1:0] ptr_addr_i,
	input  wire logic [PW-1:0] load_pkt_i,
	input  wire logic [PW-1:0] tx_pkt_i,
	input  wire logic [AW-1:0] load_addr_i,
	input  wire logic [AW-1:0] tx_addr_i,
	output logic      [2:0]    bank_code_o,
	output logic               tx_permit_o,
	output logic               crc_append_o,
	output logic               defer_en_o,
	output logic               coll_det_en_o,
	output logic               accept_own_o,
	output logic               net_tx_en_o,
	output logic      [1:0]    loop_sel_o,
	output logic               pad_en_o,
	output logic      [6:0]    pad_count_o,
	output logic               tx_abort_o,
	output logic               tx_halt_o,
	output logic               underrun_o
);
	typedef struct packed {
		logic [15:0]        transmit_control;
		logic [2:0]         bank;
		logic [15:0]        rdata;
		logic               rvalid;
		bstc_pkg::bstc_tx_e st;
		logic               permit;
		logic               crc_append;
		logic               defer_en;
		logic               coll_en;
		logic               accept_own;
		logic               net_tx_en;
		bstc_pkg::bstc_loop_e loop_sel;
		logic               pad_en;
		logic [6:0]         pad;
		logic               abort;
		logic               halt;
		logic               underrun;
	} bstc_main_s;

	localparam bstc_main_s S_RST = '{
		transmit_control:        bstc_pkg::TCR_RST,
		bank:       bstc_pkg::BANK_RST,
		rdata:      16'h0000,
		rvalid:     1'b0,
		st:         bstc_pkg::ST_IDLE,
		permit:     1'b0,
		crc_append: 1'b1,
		defer_en:   1'b1,
		coll_en:    1'b1,
		accept_own: 1'b0,
		net_tx_en:  1'b1,
		loop_sel:   bstc_pkg::LOOP_NONE,
		pad_en:     1'b0,
		pad:        7'h00,
		abort:      1'b0,
		halt:       1'b0,
		underrun:   1'b0
	};

	bstc_main_s s_q;
	bstc_main_s s_d;
	logic       carrier_s;
	logic       under_req;
	logic       bsr_hit;
	logic       tcr_hit;
	logic       no_bank;
	logic       mon_eff;
	logic       carr_fail;
	logic [10:0] pad_diff;

	// ------------------------------------------------------------
	// Carrier pin synchroniser and underrun comparator
	// ------------------------------------------------------------
	bstc_sync3 u_carrier (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (carrier_i),
		.q_o   (carrier_s)
	);

	bstc_underrun #(
		.AW (AW),
		.PW (PW)
	) u_underrun (
		.policy_i          (s_q.transmit_control[bstc_pkg::B_POLICY]),
		.early_tx_enable_i (early_tx_enable_i),
		.dma_addr_i        (dma_addr_i),
		.ptr_addr_i        (ptr_addr_i),
		.load_pkt_i        (load_pkt_i),
		.tx_pkt_i          (tx_pkt_i),
		.load_addr_i       (load_addr_i),
		.tx_addr_i         (tx_addr_i),
		.force_o           (under_req)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		s_d.abort = 1'b0;
		s_d.halt = 1'b0;
		bsr_hit = io_addr_i == bstc_pkg::OFF_BSR;
		no_bank = s_q.bank[2];
		tcr_hit = !bsr_hit && !no_bank && (s_q.bank == bstc_pkg::BANK_TX) && (io_addr_i == bstc_pkg::OFF_TCR);
		// Monitoring is off in switched mode and in either loop
		mon_eff = s_q.transmit_control[bstc_pkg::B_MON] && !s_q.transmit_control[bstc_pkg::B_SWITCHED_FULL_DUPLEX]
			&& !s_q.transmit_control[bstc_pkg::B_LOOP] && !s_q.transmit_control[bstc_pkg::B_WRAP];
		carr_fail = mon_eff && !carrier_s;

		// Bank select: blocked by power-down or by a low byte enable that is clear
		if (io_wr_i && bsr_hit && !pwrdn_i && io_be_i[0]) begin
			s_d.bank = io_wdata_i[2:0];
		end
		// Writes to an absent bank never reach tcr_hit
		if (io_wr_i && tcr_hit) begin
			if (io_be_i[0]) begin
				s_d.transmit_control[7:0] = io_wdata_i[7:0] & bstc_pkg::TCR_MASK[7:0];
			end
			if (io_be_i[1]) begin
				s_d.transmit_control[15:8] = io_wdata_i[15:8] & bstc_pkg::TCR_MASK[15:8];
			end
		end

		if (io_rd_i) begin
			s_d.rvalid = 1'b1;
			if (bsr_hit) begin
				s_d.rdata = pwrdn_i ? 16'h0000 : {bstc_pkg::SIGNATURE, 5'h00, s_q.bank};
			end else if (no_bank) begin
				s_d.rdata = {bstc_pkg::SIGNATURE, bstc_pkg::SIGNATURE};
			end else if (tcr_hit) begin
				s_d.rdata = s_q.transmit_control;
			end else begin
				s_d.rdata = 16'h0000;
			end
		end

		// --------------------------------------------------------
		// Carrier monitor across one frame
		// --------------------------------------------------------
		unique case (s_q.st)
			bstc_pkg::ST_IDLE: begin
				if (tx_start_i) begin
					s_d.st = bstc_pkg::ST_PRE;
				end
			end
			bstc_pkg::ST_PRE: begin
				if (preamble_end_i) begin
					if (carr_fail) begin
						s_d.abort = 1'b1;
						s_d.st = bstc_pkg::ST_IDLE;
					end else begin
						s_d.st = bstc_pkg::ST_BODY;
					end
				end
			end
			bstc_pkg::ST_BODY: begin
				if (carr_fail) begin
					s_d.abort = 1'b1;
					s_d.st = bstc_pkg::ST_IDLE;
				end else if (frame_end_i) begin
					s_d.st = bstc_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.st = bstc_pkg::ST_IDLE;
			end
		endcase

		// --------------------------------------------------------
		// Hardware clears win over a host write in the same cycle
		// --------------------------------------------------------
		if (signal_quality_test_fail_i && s_q.transmit_control[bstc_pkg::B_HALT] && !s_q.transmit_control[bstc_pkg::B_SWITCHED_FULL_DUPLEX]) begin
			s_d.transmit_control[bstc_pkg::B_TRANSMITTER_ON] = 1'b0;
			s_d.halt = 1'b1;
		end
		if (collision_i) begin
			s_d.transmit_control[bstc_pkg::B_FORCED_COLLISION] = 1'b0;
		end
		s_d.underrun = under_req;
		if (s_d.abort || tx_fatal_i || under_req) begin
			s_d.transmit_control[bstc_pkg::B_TRANSMITTER_ON] = 1'b0;
		end

		// --------------------------------------------------------
		// Effective controls, aligned with the stored bits
		// --------------------------------------------------------
		s_d.crc_append = !s_d.transmit_control[bstc_pkg::B_CRC_SUPPRESS];
		s_d.defer_en = !s_d.transmit_control[bstc_pkg::B_SWITCHED_FULL_DUPLEX] && !s_d.transmit_control[bstc_pkg::B_FORCED_COLLISION];
		s_d.coll_en = !s_d.transmit_control[bstc_pkg::B_SWITCHED_FULL_DUPLEX] && !s_d.transmit_control[bstc_pkg::B_LOOP]
			&& !s_d.transmit_control[bstc_pkg::B_WRAP];
		s_d.accept_own = s_d.transmit_control[bstc_pkg::B_FDX] || s_d.transmit_control[bstc_pkg::B_SWITCHED_FULL_DUPLEX];
		if (s_d.transmit_control[bstc_pkg::B_WRAP]) begin
			s_d.loop_sel = bstc_pkg::LOOP_BLOCK;
		end else if (s_d.transmit_control[bstc_pkg::B_LOOP]) begin
			s_d.loop_sel = bstc_pkg::LOOP_CODEC;
		end else begin
			s_d.loop_sel = bstc_pkg::LOOP_NONE;
		end
		s_d.net_tx_en = !s_d.transmit_control[bstc_pkg::B_WRAP] && !s_d.transmit_control[bstc_pkg::B_LOOP];
		// New frames need the enable; a running frame finishes
		s_d.permit = s_d.transmit_control[bstc_pkg::B_TRANSMITTER_ON] || (s_d.st != bstc_pkg::ST_IDLE);
		s_d.pad_en = s_d.transmit_control[bstc_pkg::B_PAD];
		// Length given by the host excludes pad bytes
		pad_diff = bstc_pkg::MIN_FRAME_LEN - frame_len_i;
		if (s_d.pad_en && (frame_len_i < bstc_pkg::MIN_FRAME_LEN)) begin
			s_d.pad = pad_diff[6:0];
		end else begin
			s_d.pad = 7'h00;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= S_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign io_rdata_o    = s_q.rdata;
	assign io_rvalid_o   = s_q.rvalid;
	assign bank_code_o   = s_q.bank;
	assign tx_permit_o   = s_q.permit;
	assign crc_append_o  = s_q.crc_append;
	assign defer_en_o    = s_q.defer_en;
	assign coll_det_en_o = s_q.coll_en;
	assign accept_own_o  = s_q.accept_own;
	assign net_tx_en_o   = s_q.net_tx_en;
	assign loop_sel_o    = s_q.loop_sel;
	assign pad_en_o      = s_q.pad_en;
	assign pad_count_o   = s_q.pad;
	assign tx_abort_o    = s_q.abort;
	assign tx_halt_o     = s_q.halt;
	assign underrun_o    = s_q.underrun;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_bsr_rd;
		io_rd_i && io_addr_i == 4'he && !pwrdn_i;
	endsequence
	sequence s_sig_back;
		io_rvalid_o && io_rdata_o[15:8] == 8'h33;
	endsequence
	property p_sig_read;
		s_bsr_rd |=> s_sig_back;
	endproperty
	a_sig_read: assert property (p_sig_read) else $error("bank select signature wrong");

	property p_bank_write;
		io_wr_i && io_addr_i == 4'he && io_be_i[0] && !pwrdn_i
			|=> bank_code_o == $past(io_wdata_i[2:0]);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank code not taken");

	property p_pwrdn;
		pwrdn_i && io_wr_i && io_addr_i == 4'he |=> $stable(bank_code_o);
	endproperty
	a_pwrdn: assert property (p_pwrdn) else $error("bank select written in power-down");

	property p_nobank_rd;
		io_rd_i && bank_code_o[2] && io_addr_i != 4'he |=> io_rdata_o == 16'h3333;
	endproperty
	a_nobank_rd: assert property (p_nobank_rd) else $error("absent bank read wrong");

	property p_nobank_wr;
		io_wr_i && bank_code_o[2] && io_addr_i == 4'h0 && !collision_i && !signal_quality_test_fail_i
			&& !tx_fatal_i && !under_req && s_d.abort == 1'b0 |=> $stable(s_q.transmit_control);
	endproperty
	a_nobank_wr: assert property (p_nobank_wr) else $error("absent bank write landed");

	property p_switched_full_duplex;
		s_q.transmit_control[15] |-> accept_own_o && !defer_en_o && !coll_det_en_o;
	endproperty
	a_switched_full_duplex: assert property (p_switched_full_duplex) else $error("switched mode controls wrong");

	property p_wrap;
		s_q.transmit_control[13] |-> loop_sel_o == 2'b10 && !net_tx_en_o && !coll_det_en_o;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap loop not selected");

	property p_halt;
		signal_quality_test_fail_i && s_q.transmit_control[12] && !s_q.transmit_control[15] |=> tx_halt_o && !s_q.transmit_control[0];
	endproperty
	a_halt: assert property (p_halt) else $error("no halt on quality error");

	property p_forced_collision;
		collision_i |=> !s_q.transmit_control[2] && defer_en_o == !s_q.transmit_control[15];
	endproperty
	a_forced_collision: assert property (p_forced_collision) else $error("forced collision not cleared");

	sequence s_no_carrier;
		s_q.st == bstc_pkg::ST_PRE && preamble_end_i && mon_eff && !carrier_s;
	endsequence
	property p_carrier;
		s_no_carrier |=> tx_abort_o && !s_q.transmit_control[0] ##1 !tx_abort_o;
	endproperty
	a_carrier: assert property (p_carrier) else $error("missing carrier not aborted");

	property p_pad;
		s_q.transmit_control[7] && io_wr_i == 1'b0 && frame_len_i < 11'h040
			|=> pad_count_o == 7'(11'h040 - $past(frame_len_i));
	endproperty
	a_pad: assert property (p_pad) else $error("pad count wrong");

	property p_underrun;
		under_req |=> underrun_o && !s_q.transmit_control[0];
	endproperty
	a_underrun: assert property (p_underrun) else $error("underrun not forced");
endmodule

//--- verification/bstc_host.sv
`timescale 1ns/100ps
module bstc_host (
	input  wire logic        clk_i,
	output logic      [3:0]  io_addr_o,
	output logic             io_wr_o,
	output logic             io_rd_o,
	output logic      [1:0]  io_be_o,
	output logic      [15:0] io_wdata_o
);
	initial begin
		io_addr_o = 4'h0;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_be_o = 2'h0;
		io_wdata_o = 16'h0000;
	end

	task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge clk_i);
		#1;
		io_addr_o = a;
		io_be_o = be;
		io_wdata_o = d & 16'hfff7;
		io_wr_o = 1'b1;
		@(posedge clk_i);
		#1;
		io_wr_o = 1'b0;
		io_wdata_o = ~io_wdata_o;
		io_be_o = ~be;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		#1;
		io_addr_o = a;
		io_rd_o = 1'b1;
		@(posedge clk_i);
		#1;
		io_rd_o = 1'b0;
		io_addr_o = ~a;
	endtask
endmodule

//--- verification/bank_select_transmit_control_bench.sv
`timescale 1ns/100ps
module bank_select_transmit_control_bench;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        pwrdn_i = 1'b0;
	logic        carrier_i = 1'b1;
	logic        tx_start_i = 1'b0, preamble_end_i = 1'b0, frame_end_i = 1'b0;
	logic        collision_i = 1'b0, signal_quality_test_fail_i = 1'b0, tx_fatal_i = 1'b0, early_tx_enable_i = 1'b0;
	logic [10:0] frame_len_i = 11'h0, dma_addr_i = 11'h0, ptr_addr_i = 11'h0, load_addr_i = 11'h0, tx_addr_i = 11'h0;
	logic [5:0]  load_pkt_i = 6'h0, tx_pkt_i = 6'h0;
	logic [3:0]  io_addr;
	logic [1:0]  io_be, loop_sel_o;
	logic [15:0] io_wdata, io_rdata_o, w;
	logic        io_wr, io_rd, io_rvalid_o, tx_permit_o, crc_append_o, defer_en_o, coll_det_en_o;
	logic        accept_own_o, net_tx_en_o, pad_en_o, tx_abort_o, tx_halt_o, underrun_o;
	logic [2:0]  bank_code_o;
	logic [6:0]  pad_count_o;
	logic [15:0] expq[$];
	int          error_cnt = 0, num_checks = 0;
	logic [15:0] ev_w [6] = '{16'h0401, 16'h8401, 16'h1001, 16'h0001, 16'h0005, 16'h0001};
	logic [15:0] ev_r [6] = '{16'h0400, 16'h8401, 16'h1000, 16'h0001, 16'h0001, 16'h0000};
	int          ev_k [6] = '{1, 1, 2, 2, 3, 4};
	logic [1:0]  ev_p [6] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b00, 2'b00};
	logic [3:0]  ur [4] = '{4'b0101, 4'b0000, 4'b1100, 4'b1111};

	always #5 clk_i = ~clk_i;

	bstc_host u_bstc_host (.clk_i(clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_rd_o(io_rd),
		.io_be_o(io_be), .io_wdata_o(io_wdata));

	bstc_top u_bstc_top (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
		.io_be_i(io_be), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
		.pwrdn_i(pwrdn_i), .carrier_i(carrier_i), .tx_start_i(tx_start_i), .preamble_end_i(preamble_end_i),
		.frame_end_i(frame_end_i), .collision_i(collision_i), .signal_quality_test_fail_i(signal_quality_test_fail_i), .tx_fatal_i(tx_fatal_i),
		.frame_len_i(frame_len_i), .early_tx_enable_i(early_tx_enable_i), .dma_addr_i(dma_addr_i),
		.ptr_addr_i(ptr_addr_i), .load_pkt_i(load_pkt_i), .tx_pkt_i(tx_pkt_i), .load_addr_i(load_addr_i),
		.tx_addr_i(tx_addr_i), .bank_code_o(bank_code_o), .tx_permit_o(tx_permit_o), .crc_append_o(crc_append_o),
		.defer_en_o(defer_en_o), .coll_det_en_o(coll_det_en_o), .accept_own_o(accept_own_o),
		.net_tx_en_o(net_tx_en_o), .loop_sel_o(loop_sel_o), .pad_en_o(pad_en_o), .pad_count_o(pad_count_o),
		.tx_abort_o(tx_abort_o), .tx_halt_o(tx_halt_o), .underrun_o(underrun_o));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic check_rd(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: read %h want %h", $time, got, exp);
		end
	endtask

	// Read results are compared in arrival order
	always @(posedge clk_i) begin
		if (io_rvalid_o === 1'b1) begin
			if (expq.size() == 0) begin
				error_cnt++;
				$display("mismatch at %0t: unexpected read", $time);
			end else
				check_rd(io_rdata_o, expq.pop_front());
		end
	end

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		expq.push_back(e);
		u_bstc_host.rd(a);
	endtask

	task automatic pulse(input int k);
		@(posedge clk_i);
		#1;
		case (k)
			0: tx_start_i = 1'b1;
			1: preamble_end_i = 1'b1;
			2: signal_quality_test_fail_i = 1'b1;
			3: collision_i = 1'b1;
			4: tx_fatal_i = 1'b1;
			default: frame_end_i = 1'b1;
		endcase
		@(posedge clk_i);
		#1;
		{tx_start_i, preamble_end_i, signal_quality_test_fail_i, collision_i, tx_fatal_i, frame_end_i} = 6'h00;
	endtask

	task automatic ctl(input logic [15:0] v);
		chk({15'h0, crc_append_o}, {15'h0, ~v[8]});
		chk({15'h0, defer_en_o}, {15'h0, ~v[15] & ~v[2]});
		chk({15'h0, coll_det_en_o}, {15'h0, ~v[15] & ~v[1] & ~v[13]});
		chk({15'h0, accept_own_o}, {15'h0, v[11] | v[15]});
		chk({15'h0, net_tx_en_o}, {15'h0, ~v[1] & ~v[13]});
		chk({14'h0, loop_sel_o}, v[13] ? 16'h0002 : {15'h0, v[1]});
		chk({15'h0, pad_en_o}, {15'h0, v[7]});
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		#1;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		ctl(16'h0000);
		rd(4'he, 16'h3300);
		rd(4'h0, 16'h0000);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#100000;
		error_cnt++;
		$display("mismatch at %0t: watchdog", $time);
		print_verdict();
	end

	initial begin
		void'($urandom(32));
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		ctl(16'h0000);
		rd(4'he, 16'h3300);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			w = 16'($urandom()) & 16'hfff7;
			u_bstc_host.wr(4'h0, 2'b11, w);
			ctl(w);
			rd(4'h0, w & bstc_pkg::TCR_MASK);
		end
		u_bstc_host.wr(4'h0, 2'b10, 16'h0000);
		rd(4'h0, {8'h00, w[7:0] & 8'h8f});
		do_reset();
		$display("test control done");
		u_bstc_host.wr(4'h0, 2'b11, 16'h0080);
		for (int c = 0; c < 8; c++) begin
			u_bstc_host.wr(4'he, 2'b11, {8'($urandom()), 5'h1f, 3'(c)});
			chk({13'h0, bank_code_o}, 16'(c));
			rd(4'he, {8'h33, 5'h00, 3'(c)});
			if (c != 0)
				u_bstc_host.wr(4'h0, 2'b11, 16'hffff);
			rd(4'h0, (c == 0) ? 16'h0080 : (c > 3) ? 16'h3333 : 16'h0000);
		end
		pwrdn_i = 1'b1;
		u_bstc_host.wr(4'he, 2'b01, 16'h0000);
		rd(4'he, 16'h0000);
		pwrdn_i = 1'b0;
		rd(4'he, 16'h3307);
		u_bstc_host.wr(4'he, 2'b01, 16'h0000);
		rd(4'h0, 16'h0080);
		$display("test bank done");
		for (int i = 0; i < 6; i++) begin
			u_bstc_host.wr(4'h0, 2'b11, ev_w[i]);
			carrier_i = (ev_k[i] != 1);
			repeat (6) @(posedge clk_i);
			if (ev_k[i] == 1)
				pulse(0);
			pulse(ev_k[i]);
			chk({14'h0, tx_halt_o, tx_abort_o}, {14'h0, ev_p[i]});
			carrier_i = 1'b1;
			rd(4'h0, ev_r[i]);
			pulse(5);
		end
		u_bstc_host.wr(4'h0, 2'b11, 16'h0001);
		chk({15'h0, tx_permit_o}, 16'h0001);
		pulse(0);
		u_bstc_host.wr(4'h0, 2'b11, 16'h0000);
		chk({15'h0, tx_permit_o}, 16'h0001);
		pulse(1);
		chk({15'h0, tx_permit_o}, 16'h0001);
		pulse(5);
		chk({15'h0, tx_permit_o}, 16'h0000);
		$display("test events done");
		u_bstc_host.wr(4'h0, 2'b11, 16'h0080);
		for (int i = 0; i < 4; i++) begin
			frame_len_i = (i < 2) ? 11'($urandom_range(63, 0)) : 11'($urandom_range(200, 63));
			repeat (2) @(posedge clk_i);
			#1;
			chk({9'h0, pad_count_o}, (frame_len_i < 11'd64) ? 16'(11'd64 - frame_len_i) : 16'h0);
		end
		frame_len_i = 11'h005;
		u_bstc_host.wr(4'h0, 2'b11, 16'h0000);
		repeat (2) @(posedge clk_i);
		#1;
		chk({9'h0, pad_count_o}, 16'h0000);
		$display("test pad done");
		for (int i = 0; i < 4; i++) begin
			u_bstc_host.wr(4'h0, 2'b11, {1'b0, ur[i][3], 13'h0, 1'b1});
			ptr_addr_i = 11'($urandom_range(1000, 0));
			load_addr_i = 11'($urandom_range(1000, 0));
			dma_addr_i = ptr_addr_i + {10'h0, ~ur[i][3]};
			tx_addr_i = load_addr_i + {10'h0, ur[i][3]};
			tx_pkt_i = 6'($urandom());
			load_pkt_i = ur[i][1] ? tx_pkt_i : tx_pkt_i + 6'h1;
			early_tx_enable_i = ur[i][2];
			@(posedge clk_i);
			#1;
			chk({15'h0, underrun_o}, {15'h0, ur[i][0]});
			early_tx_enable_i = 1'b0;
			rd(4'h0, {1'b0, ur[i][3], 13'h0, ~ur[i][0]});
		end
		$display("test underrun done");
		repeat (3) @(posedge clk_i);
		chk(16'(expq.size()), 16'h0000);
		print_verdict();
	end
endmodule
